/* common/cil_consts.vh */
// constants for the camera i/o line control block
`ifndef CIL_CONSTS_VH
`define CIL_CONSTS_VH

// ------------------------------------------------------------
// geometry
// ------------------------------------------------------------
`define CIL_NUM_LINES      5
`define CIL_CNT_W          16
// fixed line directions, 1 = output (line 1 and 2,3 drive)
`define CIL_DIR_MAP        5'h0E

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CIL_CLK_NS         50
`define CIL_US_NS          1000
`define CIL_TICK_CYC       ((`CIL_US_NS + `CIL_CLK_NS - 1) / `CIL_CLK_NS)

// ------------------------------------------------------------
// register word addresses
// ------------------------------------------------------------
`define CIL_A_PICK         4'h0
`define CIL_A_CFG          4'h1
`define CIL_A_DELAY        4'h2
`define CIL_A_WIDTH        4'h3
`define CIL_A_APPLY        4'h4
`define CIL_A_ALL          4'h5
`define CIL_A_FL_DELAY     4'h6
`define CIL_A_FL_WIDTH     4'h7

// ------------------------------------------------------------
// line configuration word fields
// ------------------------------------------------------------
`define CIL_F_INV          0
`define CIL_F_SRC_LO       1
`define CIL_F_SRC_HI       3
`define CIL_F_LATCH        4
`define CIL_F_SWLVL        5
`define CIL_F_DIR          6
`define CIL_F_LEVEL        7

// ------------------------------------------------------------
// output source codes
// ------------------------------------------------------------
`define CIL_SRC_SW         3'h0
`define CIL_SRC_TRIG       3'h1
`define CIL_SRC_READOUT    3'h2
`define CIL_SRC_EXPO       3'h3
`define CIL_SRC_READY      3'h4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define CIL_RST_PICK       3'h0
`define CIL_RST_SRC        3'h0
`define CIL_RST_DELAY      16'h0000
`define CIL_RST_WIDTH      16'h000A

`endif

/* logic/cil_line_ctrl.v */
// camera general-purpose i/o line control with register port
//
// Summary of operation
// R1: per-line settings and readback apply only to the line chosen by line_pick.
// R2: polarity invert flips the chosen line's signal, input or output.
// R3: status read returns present logic level of the chosen line.
// R4: line direction of the chosen line is reported read-only.
// R5: software source drives the line from the software output level.
// R6: trigger-pulse source emits one pulse after a trigger event; a new event before it ends restarts it.
// R7: readout source emits one pulse after sensor readout begins; a new begin before it ends restarts it.
// R8: exposure source holds the line active exactly during exposure.
// R9: trigger-ready source holds the line active while a trigger is accepted.
// R10: pulse sources wait a programmable microsecond delay after the event.
// R11: pulse sources hold each pulse for a programmable microsecond width.
// R12: unlatched software level reaches the line as soon as written.
// R13: latched software level waits pending until the apply command.
// R14: active level closes the output circuit, inactive opens it.
// R15: all line levels, sampled at read, packed as one vector.
// R16: read-only recommended delay equals last sensor line start delay.
// R17: read-only recommended width for the best flash window.
// R18: microsecond tick from clock times pulses; new event restarts delay.
`timescale 1ns/100ps
`default_nettype none
`include "cil_consts.vh"

module cil_line_ctrl (
    // clock and reset
    input  wire        ref_clk,
    input  wire        sys_rst,
    // register port
    input  wire [3:0]  regAddr,
    input  wire [31:0] regWrData,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdData,
    // camera timing events, same clock
    input  wire        trigEvent,
    input  wire        readoutBegin,
    input  wire        source_exposure_window,
    input  wire        triggerReady,
    // sensor timing for flash recommendation
    input  wire [15:0] lastLineDelayUs,
    input  wire [15:0] flashWindowUs,
    // connector lines
    input  wire [4:0]  linePinIn,
    output reg  [4:0]  lineOut,
    output reg  [4:0]  lineOe
);

    // --------------------------------------------------------
    // local states and widths
    // --------------------------------------------------------
    localparam NL      = `CIL_NUM_LINES;
    localparam CW      = `CIL_CNT_W;
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_HIGH = 2'h2;
    localparam [31:0] TICK_LAST_W = `CIL_TICK_CYC - 1;
    localparam [4:0]  TICK_LAST   = TICK_LAST_W[4:0];
    localparam [NL-1:0] DIR_MAP = `CIL_DIR_MAP;

    // --------------------------------------------------------
    // pin synchroniser, two flops before any use
    // --------------------------------------------------------
    reg [NL-1:0] pinMeta_ff;
    reg [NL-1:0] pinSync_ff;

    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pinMeta_ff <= {NL{1'b0}};
            pinSync_ff <= {NL{1'b0}};
        end else begin
            pinMeta_ff <= linePinIn;
            pinSync_ff <= pinMeta_ff;
        end
    end

    // --------------------------------------------------------
    // microsecond tick
    // --------------------------------------------------------
    reg [4:0] tickCnt_ff;
    reg       usTick_ff;

    // one-cycle enable every microsecond
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            tickCnt_ff <= 5'h00;
            usTick_ff  <= 1'b0;
        end else if (tickCnt_ff == TICK_LAST) begin
            tickCnt_ff <= 5'h00;
            usTick_ff  <= 1'b1; // R18
        end else begin
            tickCnt_ff <= tickCnt_ff + 5'h01;
            usTick_ff  <= 1'b0;
        end
    end

    // --------------------------------------------------------
    // line selection and global register decode
    // --------------------------------------------------------
    reg  [2:0] pick_ff;
    wire       wrCfg   = regWr && (regAddr == `CIL_A_CFG);
    wire       wrDelay = regWr && (regAddr == `CIL_A_DELAY);
    wire       wrWidth = regWr && (regAddr == `CIL_A_WIDTH);
    wire       wrApply = regWr && (regAddr == `CIL_A_APPLY);

    // chosen line index
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pick_ff <= `CIL_RST_PICK;
        end else if (regWr && (regAddr == `CIL_A_PICK)) begin
            pick_ff <= regWrData[2:0];
        end
    end

    // --------------------------------------------------------
    // per-line state, flattened for the readback mux
    // --------------------------------------------------------
    wire [NL-1:0]    invVec;
    wire [NL-1:0]    latchVec;
    wire [NL-1:0]    swVec;
    wire [NL-1:0]    levelVec;
    wire [3*NL-1:0]  srcVec;
    wire [CW*NL-1:0] delayVec;
    wire [CW*NL-1:0] widthVec;
    wire [NL-1:0]    nxt_lineOut;

    genvar gi;
    generate
        for (gi = 0; gi < NL; gi = gi + 1) begin : g_line
            reg          inv_ff;
            reg  [2:0]   src_ff;
            reg          latch_ff;
            reg          swLevel_ff;
            reg          applied_ff;
            reg  [CW-1:0] delay_ff;
            reg  [CW-1:0] width_ff;
            reg  [1:0]   pst_ff;
            reg  [CW-1:0] pcnt_ff;
            reg          drive;
            wire         sel = (pick_ff == gi); // R1
            wire         evt = (src_ff == `CIL_SRC_TRIG) ? trigEvent :
                               (src_ff == `CIL_SRC_READOUT) ? readoutBegin :
                               1'b0;

            // configuration written only through the chosen line
            always @(posedge ref_clk) begin
                if (sys_rst) begin
                    inv_ff     <= 1'b0;
                    src_ff     <= `CIL_RST_SRC;
                    latch_ff   <= 1'b0;
                    swLevel_ff <= 1'b0;
                    delay_ff   <= `CIL_RST_DELAY;
                    width_ff   <= `CIL_RST_WIDTH;
                end else if (sel) begin // R1
                    if (wrCfg) begin
                        inv_ff     <= regWrData[`CIL_F_INV];
                        src_ff     <= regWrData[`CIL_F_SRC_HI:`CIL_F_SRC_LO];
                        latch_ff   <= regWrData[`CIL_F_LATCH];
                        swLevel_ff <= regWrData[`CIL_F_SWLVL];
                    end
                    if (wrDelay) begin
                        delay_ff <= regWrData[CW-1:0]; // R10
                    end
                    if (wrWidth) begin
                        width_ff <= regWrData[CW-1:0]; // R11
                    end
                end
            end

            // level that reaches the pin: direct or held until apply
            always @(posedge ref_clk) begin
                if (sys_rst) begin
                    applied_ff <= 1'b0;
                end else if (sel && wrCfg && !regWrData[`CIL_F_LATCH]) begin
                    applied_ff <= regWrData[`CIL_F_SWLVL]; // R12
                end else if (sel && wrApply && latch_ff) begin
                    applied_ff <= swLevel_ff; // R13
                end
            end

            // pulse generator: delay then width, event restarts delay
            always @(posedge ref_clk) begin
                if (sys_rst) begin
                    pst_ff  <= ST_IDLE;
                    pcnt_ff <= {CW{1'b0}};
                end else if (evt) begin
                    pst_ff  <= ST_WAIT; // R6 R7 R18
                    pcnt_ff <= delay_ff; // R10
                end else begin
                    case (pst_ff)
                        ST_WAIT: begin
                            // leave only on a tick so the pulse lasts whole microseconds
                            if (usTick_ff) begin
                                if (pcnt_ff <= {{(CW-1){1'b0}}, 1'b1}) begin
                                    pst_ff  <= ST_HIGH;
                                    pcnt_ff <= width_ff; // R11
                                end else begin
                                    pcnt_ff <= pcnt_ff - 1'b1; // R10
                                end
                            end
                        end
                        ST_HIGH: begin
                            if (pcnt_ff == {CW{1'b0}}) begin
                                pst_ff <= ST_IDLE;
                            end else if (usTick_ff) begin
                                pcnt_ff <= pcnt_ff - 1'b1; // R11
                            end
                        end
                        default: begin
                            pst_ff <= ST_IDLE;
                        end
                    endcase
                end
            end

            // source select before polarity
            always @* begin
                case (src_ff)
                    `CIL_SRC_SW:      drive = applied_ff; // R5
                    `CIL_SRC_TRIG:    drive = (pst_ff == ST_HIGH) &&
                                              (pcnt_ff != {CW{1'b0}}); // R6
                    `CIL_SRC_READOUT: drive = (pst_ff == ST_HIGH) &&
                                              (pcnt_ff != {CW{1'b0}}); // R7
                    `CIL_SRC_EXPO:    drive = source_exposure_window; // R8
                    `CIL_SRC_READY:   drive = triggerReady; // R9
                    default:          drive = 1'b0;
                endcase
            end

            // 1 closes the output circuit, 0 opens it
            assign nxt_lineOut[gi] = DIR_MAP[gi] & (drive ^ inv_ff); // R2 R14
            assign invVec[gi]      = inv_ff;
            assign latchVec[gi]    = latch_ff;
            assign swVec[gi]       = swLevel_ff;
            assign srcVec[3*gi+2:3*gi]     = src_ff;
            assign delayVec[CW*gi+CW-1:CW*gi] = delay_ff;
            assign widthVec[CW*gi+CW-1:CW*gi] = width_ff;
            assign levelVec[gi]    = pinSync_ff[gi] ^ inv_ff; // R2 R3
        end
    endgenerate

    // --------------------------------------------------------
    // pin drivers, straight from flops
    // --------------------------------------------------------
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            lineOut <= {NL{1'b0}};
            lineOe  <= {NL{1'b0}};
        end else begin
            lineOut <= nxt_lineOut;
            lineOe  <= DIR_MAP; // R4
        end
    end

    // --------------------------------------------------------
    // read data, one cycle after the strobe, zero when unmapped
    // --------------------------------------------------------
    reg [31:0] nxt_regRdData;
    wire       pickOk = (pick_ff < NL);

    always @* begin
        nxt_regRdData = 32'h0000_0000;
        case (regAddr)
            `CIL_A_PICK: begin
                nxt_regRdData[2:0] = pick_ff;
            end
            `CIL_A_CFG: begin
                if (pickOk) begin // R1
                    nxt_regRdData[`CIL_F_INV]   = invVec[pick_ff];
                    nxt_regRdData[`CIL_F_SRC_HI:`CIL_F_SRC_LO] =
                        srcVec[3*pick_ff +: 3];
                    nxt_regRdData[`CIL_F_LATCH] = latchVec[pick_ff];
                    nxt_regRdData[`CIL_F_SWLVL] = swVec[pick_ff];
                    nxt_regRdData[`CIL_F_DIR]   = DIR_MAP[pick_ff]; // R4
                    nxt_regRdData[`CIL_F_LEVEL] = levelVec[pick_ff]; // R3
                end
            end
            `CIL_A_DELAY: begin
                if (pickOk) begin
                    nxt_regRdData[CW-1:0] = delayVec[CW*pick_ff +: CW];
                end
            end
            `CIL_A_WIDTH: begin
                if (pickOk) begin
                    nxt_regRdData[CW-1:0] = widthVec[CW*pick_ff +: CW];
                end
            end
            `CIL_A_ALL: begin
                nxt_regRdData[NL-1:0] = levelVec; // R15
            end
            `CIL_A_FL_DELAY: begin
                nxt_regRdData[15:0] = lastLineDelayUs; // R16
            end
            `CIL_A_FL_WIDTH: begin
                nxt_regRdData[15:0] = flashWindowUs; // R17
            end
            default: begin
                nxt_regRdData = 32'h0000_0000;
            end
        endcase
    end

    // answer register, cleared outside read cycles
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            regRdData <= 32'h0000_0000;
        end else if (regRd) begin
            regRdData <= nxt_regRdData;
        end else begin
            regRdData <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

/* test/cil_checker.sv */
// port-level assertion checker for the camera i/o line block
`timescale 1ns/100ps
`default_nettype none
`include "cil_consts.vh"
module cil_checker (
    // clock, reset and register port
    input wire logic        ref_clk,
    input wire logic        sys_rst,
    input wire logic [3:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [31:0] regRdData,
    // camera timing and connector lines
    input wire logic        source_exposure_window,
    input wire logic        triggerReady,
    input wire logic [15:0] lastLineDelayUs,
    input wire logic [15:0] flashWindowUs,
    input wire logic [4:0]  lineOut,
    input wire logic [4:0]  lineOe
);
    // ----
    // shadow of line pick, sources and inversion
    // ----
    logic [2:0] pick_ff;
    logic [2:0] src_ff [0:4];
    logic [4:0] inv_ff;
    wire  [4:0] dirMap = `CIL_DIR_MAP;
    wire        pickDir = dirMap[pick_ff];
    // follow register writes the way software sees them
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pick_ff <= 3'h0;
            inv_ff <= 5'h00;
            for (int i = 0; i < 5; i++) src_ff[i] <= 3'h0;
        end else if (regWr && regAddr == `CIL_A_PICK) begin
            pick_ff <= regWrData[2:0];
        end else if (regWr && regAddr == `CIL_A_CFG && pick_ff < 3'h5) begin
            src_ff[pick_ff] <= regWrData[3:1];
            inv_ff[pick_ff] <= regWrData[0];
        end
    end
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    a_oe_map: assert property (!$past(sys_rst) |-> lineOe == `CIL_DIR_MAP)
        else $error("output enables differ from direction map");
    a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
        else $error("read data outside answer cycle");
    a_flash_delay: assert property (regRd && regAddr == `CIL_A_FL_DELAY |=>
        regRdData == {16'h0, $past(lastLineDelayUs)}) else $error("flash delay read");
    a_flash_width: assert property (regRd && regAddr == `CIL_A_FL_WIDTH |=>
        regRdData == {16'h0, $past(flashWindowUs)}) else $error("flash width read");
    a_dir_report: assert property (regRd && regAddr == `CIL_A_CFG && pick_ff < 3'h5
        |=> regRdData[`CIL_F_DIR] == $past(pickDir)) else $error("direction bit");
    a_pick_refused: assert property (regRd && regAddr == `CIL_A_CFG && pick_ff > 3'h4
        |=> regRdData == 32'h0) else $error("read of missing line");
    a_expo_rise: assert property (src_ff[2] == `CIL_SRC_EXPO && !inv_ff[2]
        && $rose(source_exposure_window) |-> ##[1:3] lineOut[2]) else $error("exposure start");
    a_expo_fall: assert property (src_ff[2] == `CIL_SRC_EXPO && !inv_ff[2]
        && $fell(source_exposure_window) |-> ##[1:3] !lineOut[2]) else $error("exposure end");
    a_ready_level: assert property ((src_ff[3] == `CIL_SRC_READY && !inv_ff[3]
        && triggerReady)[*4] |-> lineOut[3]) else $error("trigger ready level");
endmodule
`default_nettype wire

/* test/cil_far_end.sv */
// flash and trigger equipment on the camera connector
`timescale 1ns/100ps
`default_nettype none
module cil_far_end (
    // clock for the firing counter
    input  wire logic       ref_clk,
    // camera drive and the equipment's own input levels
    input  wire logic [4:0] lineOut,
    input  wire logic [4:0] lineOe,
    input  wire logic [4:0] extLevel,
    // connector levels and flash firings seen on line 1
    output logic      [4:0] linePinIn,
    output logic      [7:0] pulseCnt
);
    logic       prevPin = 1'b0;
    logic [7:0] fire_ff = 8'h00;
    // closed output circuit reads high, open one reads low, input lines follow the equipment
    assign linePinIn = (lineOe & lineOut) | (~lineOe & extLevel);
    assign pulseCnt = fire_ff;
    // flash fires once per rising level on line 1
    always @(posedge ref_clk) begin
        prevPin <= linePinIn[1];
        if (linePinIn[1] && !prevPin) fire_ff <= fire_ff + 8'h01;
    end
endmodule
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the camera i/o line block
`timescale 1ns/100ps
`default_nettype none
`include "cil_consts.vh"
module tb;
    logic        ref_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic        trigEvent = 1'b0;
    logic        readoutBegin = 1'b0;
    logic        source_exposure_window = 1'b0;
    logic        triggerReady = 1'b0;
    logic [15:0] lastLineDelayUs = 16'h0;
    logic [15:0] flashWindowUs = 16'h0;
    logic [4:0]  extLevel = 5'h00;
    logic [4:0]  dirMap = `CIL_DIR_MAP;
    wire  [31:0] regRdData;
    wire  [4:0]  linePinIn;
    wire  [4:0]  lineOut;
    wire  [4:0]  lineOe;
    wire  [7:0]  pulseCnt;
    logic [31:0] seed = 32'h0000_0018;
    logic [31:0] expQ[$];
    logic [31:0] mskQ[$];
    logic        rdLag = 1'b0;
    int          err_total = 0;
    int          n_checks = 0;
    int          cyc = 0;
    cil_line_ctrl cil_line_ctrl_inst (.ref_clk, .sys_rst, .regAddr, .regWrData, .regWr,
        .regRd, .regRdData, .trigEvent, .readoutBegin, .source_exposure_window, .triggerReady,
        .lastLineDelayUs, .flashWindowUs, .linePinIn, .lineOut, .lineOe);
    cil_far_end cil_far_end_inst (.ref_clk, .lineOut, .lineOe, .extLevel, .linePinIn,
        .pulseCnt);
    always #25 ref_clk = ~ref_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    // the answer is noted here and judged by the watcher below
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        expQ.push_back(e & m);
        mskQ.push_back(m);
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    // fire an event (twice when asked) and time the pulse on line 1
    task automatic pulse(input int d, input int w, input bit ro, input bit twice);
        int t;
        int h;
        logic [7:0] c0;
        c0 = pulseCnt;
        @(posedge ref_clk);
        if (ro) readoutBegin <= 1'b1;
        else trigEvent <= 1'b1;
        @(posedge ref_clk);
        trigEvent <= 1'b0;
        readoutBegin <= 1'b0;
        if (twice) begin
            repeat (29) @(posedge ref_clk);
            trigEvent <= 1'b1;
            @(posedge ref_clk);
            trigEvent <= 1'b0;
        end
        t = 1;
        h = 0;
        // look at the pin drive between edges, where it is settled
        @(negedge ref_clk);
        while (lineOut[1] !== 1'b1 && t < 500) begin @(negedge ref_clk); t++; end
        while (lineOut[1] === 1'b1 && h < 500) begin @(negedge ref_clk); h++; end
        chk("pulse delay", 1, t >= d * 20 - 17 && t <= d * 20 + 2);
        chk("pulse width", w * 20, h);
        chk("pulse count", c0 + 1, pulseCnt);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // read answers stand only in the cycle after the strobe
    always @(posedge ref_clk) rdLag <= regRd;
    always @(negedge ref_clk) begin
        if (rdLag) chk("read data", expQ.pop_front(), regRdData & mskQ.pop_front());
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        rd(`CIL_A_DELAY, `CIL_RST_DELAY, '1);
        rd(`CIL_A_WIDTH, `CIL_RST_WIDTH, '1);
        rd(4'hB, 32'h0, '1);
        for (int k = 0; k < 6; k++) begin
            wr(`CIL_A_PICK, k);
            rd(`CIL_A_CFG, k < 5 ? dirMap[k] << 6 : 0, k < 5 ? 32'hFFFF_FF7F : '1);
        end
        rd(`CIL_A_DELAY, 32'h0000_0000, '1);
        wr(`CIL_A_PICK, 1);
        seed = xs(seed);
        wr(`CIL_A_DELAY, seed[15:0]);
        rd(`CIL_A_DELAY, seed[15:0], '1);
        wr(`CIL_A_CFG, 32'h20);
        settle(2);
        chk("soft level", 1, lineOut[1]);
        rd(`CIL_A_CFG, 32'hE0, 32'hFF);
        wr(`CIL_A_CFG, 32'h21);
        settle(2);
        chk("inverted out", 0, lineOut[1]);
        rd(`CIL_A_CFG, 32'hE1, 32'hFF);
        wr(`CIL_A_CFG, 32'h10);
        settle(3);
        chk("latch pending", 1, lineOut[1]);
        wr(`CIL_A_APPLY, 0);
        settle(2);
        chk("latch applied", 0, lineOut[1]);
        wr(`CIL_A_CFG, 0);
        for (int k = 0; k < 4; k++) begin
            seed = xs(seed);
            @(posedge ref_clk);
            extLevel <= seed[4:0];
            settle(3);
            rd(`CIL_A_ALL, seed[4:0] & 5'h11, '1);
        end
        wr(`CIL_A_PICK, 0);
        wr(`CIL_A_CFG, 1);
        rd(`CIL_A_CFG, {~extLevel[0], 7'h01}, 32'h81);
        wr(`CIL_A_PICK, 1);
        wr(`CIL_A_DELAY, 3);
        wr(`CIL_A_WIDTH, 2);
        wr(`CIL_A_CFG, {`CIL_SRC_TRIG, 1'b0});
        pulse(3, 2, 0, 0);
        pulse(3, 2, 0, 1);
        wr(`CIL_A_CFG, {`CIL_SRC_READOUT, 1'b0});
        pulse(3, 2, 1, 0);
        for (int j = 2; j < 4; j++) begin
            wr(`CIL_A_PICK, j);
            wr(`CIL_A_CFG, {j == 2 ? `CIL_SRC_EXPO : `CIL_SRC_READY, 1'b0});
            repeat (3) begin
                @(posedge ref_clk);
                source_exposure_window <= ~source_exposure_window;
                triggerReady <= ~triggerReady;
                settle(3);
                chk("level source", j == 2 ? source_exposure_window : triggerReady, lineOut[j]);
            end
        end
        seed = xs(seed);
        @(posedge ref_clk);
        lastLineDelayUs <= seed[15:0];
        flashWindowUs <= seed[31:16];
        rd(`CIL_A_FL_DELAY, seed[15:0], '1);
        rd(`CIL_A_FL_WIDTH, seed[31:16], '1);
        settle(2);
        report_and_stop();
    end
endmodule
bind cil_line_ctrl cil_checker cil_checker_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .source_exposure_window(source_exposure_window), .triggerReady(triggerReady),
    .lastLineDelayUs(lastLineDelayUs), .flashWindowUs(flashWindowUs),
    .lineOut(lineOut), .lineOe(lineOe));
`default_nettype wire
